// *** core/byte_move_execute_unit.sv ***
// byte move sequencer: addressing, state counting, bus operand and flag update
`timescale 1ns/100ps
module byte_move_execute_unit (
	input wire logic clock_in,
	input wire logic srst_in,
	input wire logic instr_valid_in,
	input wire byte_move_pkg::mode_t instr_mode_in,
	input wire logic [3:0] instr_dst_in,
	input wire logic [3:0] instr_src_in,
	input wire logic [23:0] instr_ext_in,
	output logic instr_ready_out,
	output logic done_out,
	output logic [3:0] instr_len_out,
	output logic [3:0] instr_states_out,
	output logic [7:0] flags_out,
	output logic mem_req_out,
	output logic mem_we_out,
	output logic [23:0] mem_addr_out,
	output logic [7:0] mem_wdata_out,
	input wire logic mem_ack_in,
	input wire logic [7:0] mem_rdata_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out
);
	typedef struct packed {
		byte_move_pkg::phase_t phase;
		byte_move_pkg::mode_t mode;
		logic [3:0] dst;
		logic [3:0] src;
		logic [23:0] ext;
		logic [3:0] cnt;
		logic mem_pend;
		logic have_data;
		logic [7:0] data;
		logic [23:0] addr;
		logic [7:0] flags;
		logic done;
		logic [3:0] len;
		logic [3:0] states;
		logic req;
		logic we;
		logic [7:0] wdata;
		logic [31:0] rdata;
	} exec_state_t;
	exec_state_t s_r;
	exec_state_t s_nxt;

	reg_file_if rf ();

	general_reg_file u_regs (
		.clock_in(clock_in),
		.srst_in(srst_in),
		.rf(rf)
	);

	// length in bytes and state count per addressing mode
	// limitation: only the byte group is decoded, so no length ever exceeds eight bytes
	function automatic logic [7:0] timing_of(input byte_move_pkg::mode_t m);
		unique case (m)
			byte_move_pkg::MODE_IMM: return {byte_move_pkg::LEN_2, byte_move_pkg::ST_2};
			byte_move_pkg::MODE_REG: return {byte_move_pkg::LEN_2, byte_move_pkg::ST_2};
			byte_move_pkg::MODE_IND: return {byte_move_pkg::LEN_2, byte_move_pkg::ST_4};
			byte_move_pkg::MODE_DISP16: return {byte_move_pkg::LEN_4, byte_move_pkg::ST_6};
			byte_move_pkg::MODE_DISP24: return {byte_move_pkg::LEN_8, byte_move_pkg::ST_10};
			byte_move_pkg::MODE_POSTINC: return {byte_move_pkg::LEN_2, byte_move_pkg::ST_6};
			byte_move_pkg::MODE_ABS8: return {byte_move_pkg::LEN_2, byte_move_pkg::ST_4};
			byte_move_pkg::MODE_ABS16: return {byte_move_pkg::LEN_4, byte_move_pkg::ST_6};
			byte_move_pkg::MODE_ABS24: return {byte_move_pkg::LEN_6, byte_move_pkg::ST_8};
			default: return {byte_move_pkg::LEN_2, byte_move_pkg::ST_4};
		endcase
	endfunction

	// immediate and register forms never touch memory
	function automatic logic uses_bus(input byte_move_pkg::mode_t m);
		return !(m == byte_move_pkg::MODE_IMM || m == byte_move_pkg::MODE_REG);
	endfunction

	logic [23:0] base_addr;
	logic [23:0] ea;
	logic start;
	logic finish;
	logic [7:0] moved;
	logic [7:0] tm;

	assign start = (s_r.phase == byte_move_pkg::PH_IDLE) && instr_valid_in;
	assign tm = timing_of(instr_mode_in);
	assign base_addr = rf.long_rd_data[23:0];
	// the long read port follows the latched source (or destination for the store form)
	assign rf.long_rd_idx = (s_r.mode == byte_move_pkg::MODE_STORE_IND) ? s_r.dst[2:0] : s_r.src[2:0];
	// the source byte feeds register moves and the store data alike
	assign rf.byte_rd_idx = s_r.src;
	assign rf.dbg_rd_idx = reg_addr_in[2:0];

	always_comb begin
		unique case (s_r.mode)
			byte_move_pkg::MODE_DISP16: ea = base_addr + {{8{s_r.ext[15]}}, s_r.ext[15:0]};
			byte_move_pkg::MODE_DISP24: ea = base_addr + s_r.ext;
			byte_move_pkg::MODE_ABS8: ea = {byte_move_pkg::ABS8_PAGE, s_r.ext[7:0]};
			byte_move_pkg::MODE_ABS16: ea = {{8{s_r.ext[15]}}, s_r.ext[15:0]};
			byte_move_pkg::MODE_ABS24: ea = s_r.ext;
			default: ea = base_addr;
		endcase
	end

	// last state reached and, for any bus form (load or store), the acknowledge has been taken
	assign finish = (s_r.phase == byte_move_pkg::PH_RUN) && (s_r.cnt == 4'h1)
		&& (!uses_bus(s_r.mode) || s_r.have_data);

	always_comb begin
		unique case (s_r.mode)
			byte_move_pkg::MODE_IMM: moved = s_r.ext[7:0];
			byte_move_pkg::MODE_REG: moved = rf.byte_rd_data;
			byte_move_pkg::MODE_STORE_IND: moved = rf.byte_rd_data;
			default: moved = s_r.data;
		endcase
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.req = 1'b0;
		s_nxt.we = 1'b0;
		rf.byte_wr_en = 1'b0;
		rf.byte_wr_idx = s_r.dst;
		rf.byte_wr_data = moved;
		rf.long_wr_en = 1'b0;
		rf.long_wr_idx = s_r.src[2:0];
		rf.long_wr_data = rf.long_rd_data + 32'h00000001;
		if (reg_rd_in) begin
			s_nxt.rdata = (reg_addr_in == byte_move_pkg::OFS_FLAGS) ? {24'h000000, s_r.flags}
				: (reg_addr_in[3] ? 32'h00000000 : rf.dbg_rd_data);
		end
		// port writes are only taken while idle so they never race an instruction
		if (reg_wr_in && s_r.phase == byte_move_pkg::PH_IDLE && !instr_valid_in) begin
			if (reg_addr_in == byte_move_pkg::OFS_FLAGS) begin
				s_nxt.flags = reg_wdata_in[7:0];
			end else if (!reg_addr_in[3]) begin
				rf.long_wr_en = 1'b1;
				rf.long_wr_idx = reg_addr_in[2:0];
				rf.long_wr_data = reg_wdata_in;
			end
		end
		unique case (s_r.phase)
			byte_move_pkg::PH_IDLE: begin
				if (start) begin
					s_nxt.phase = byte_move_pkg::PH_RUN;
					s_nxt.mode = instr_mode_in;
					s_nxt.dst = instr_dst_in;
					s_nxt.src = instr_src_in;
					s_nxt.ext = instr_ext_in;
					s_nxt.len = tm[7:4];
					s_nxt.states = tm[3:0];
					s_nxt.cnt = tm[3:0];
					s_nxt.mem_pend = uses_bus(instr_mode_in);
					s_nxt.have_data = 1'b0;
				end
			end
			byte_move_pkg::PH_RUN: begin
				if (s_r.cnt != 4'h1) begin
					s_nxt.cnt = s_r.cnt - 4'h1;
				end
				// one operand access per bus-form instruction, issued in the first busy cycle
				if (s_r.mem_pend) begin
					s_nxt.mem_pend = 1'b0;
					s_nxt.req = 1'b1;
					s_nxt.we = (s_r.mode == byte_move_pkg::MODE_STORE_IND);
					s_nxt.addr = ea;
					s_nxt.wdata = rf.byte_rd_data;
				end
				// a slow acknowledge only stretches the count; the operand is kept until finish
				if (mem_ack_in && !s_r.mem_pend) begin
					s_nxt.have_data = 1'b1;
					s_nxt.data = mem_rdata_in;
				end
				if (finish) begin
					s_nxt.phase = byte_move_pkg::PH_IDLE;
					s_nxt.done = 1'b1;
					s_nxt.flags[byte_move_pkg::FLAG_N] = moved[7];
					s_nxt.flags[byte_move_pkg::FLAG_Z] = (moved == 8'h00);
					s_nxt.flags[byte_move_pkg::FLAG_V] = 1'b0;
					// carry, half-carry and the mask bits are carried over untouched
					s_nxt.flags[byte_move_pkg::FLAG_C] = s_r.flags[byte_move_pkg::FLAG_C];
					s_nxt.flags[byte_move_pkg::FLAG_H] = s_r.flags[byte_move_pkg::FLAG_H];
					s_nxt.flags[byte_move_pkg::FLAG_I] = s_r.flags[byte_move_pkg::FLAG_I];
					s_nxt.flags[byte_move_pkg::FLAG_UI] = s_r.flags[byte_move_pkg::FLAG_UI];
					s_nxt.flags[byte_move_pkg::FLAG_U] = s_r.flags[byte_move_pkg::FLAG_U];
					// the store form writes memory, not a register
					if (s_r.mode != byte_move_pkg::MODE_STORE_IND) begin
						rf.byte_wr_en = 1'b1;
					end
					if (s_r.mode == byte_move_pkg::MODE_POSTINC) begin
						rf.long_wr_en = 1'b1;
						rf.long_wr_idx = s_r.src[2:0];
						rf.long_wr_data = rf.long_rd_data + 32'h00000001;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			s_r <= '0;
			s_r.flags <= byte_move_pkg::FLAGS_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign instr_ready_out = (s_r.phase == byte_move_pkg::PH_IDLE);
	assign done_out = s_r.done;
	assign instr_len_out = s_r.len;
	assign instr_states_out = s_r.states;
	assign flags_out = s_r.flags;
	assign mem_req_out = s_r.req;
	assign mem_we_out = s_r.we;
	assign mem_addr_out = s_r.addr;
	assign mem_wdata_out = s_r.wdata;
	assign reg_rdata_out = s_r.rdata;
endmodule

// *** common/byte_move_pkg.sv ***
// shared constants and types for the byte move execute unit
package byte_move_pkg;
	localparam int ADDR_W = 24;
	localparam int REG_CNT = 8;
	localparam int IDX_W = 3;
	// flag bit positions inside condition_flags_register
	localparam int FLAG_I = 7;
	localparam int FLAG_UI = 6;
	localparam int FLAG_H = 5;
	localparam int FLAG_U = 4;
	localparam int FLAG_N = 3;
	localparam int FLAG_Z = 2;
	localparam int FLAG_V = 1;
	localparam int FLAG_C = 0;
	localparam logic [7:0] FLAGS_RESET = 8'h80;
	localparam logic [31:0] LONG_RESET = 32'h00000000;
	// plain register port map
	localparam logic [3:0] OFS_LONG0 = 4'h0;
	localparam logic [3:0] OFS_FLAGS = 4'h8;
	// upper bits of a short absolute address
	localparam logic [15:0] ABS8_PAGE = 16'hFFFF;
	// lengths in bytes and state counts
	localparam logic [3:0] LEN_2 = 4'h2;
	localparam logic [3:0] LEN_4 = 4'h4;
	localparam logic [3:0] LEN_6 = 4'h6;
	localparam logic [3:0] LEN_8 = 4'h8;
	localparam logic [3:0] ST_2 = 4'h2;
	localparam logic [3:0] ST_4 = 4'h4;
	localparam logic [3:0] ST_6 = 4'h6;
	localparam logic [3:0] ST_8 = 4'h8;
	localparam logic [3:0] ST_10 = 4'hA;
	typedef enum logic [3:0] {
		MODE_IMM,
		MODE_REG,
		MODE_IND,
		MODE_DISP16,
		MODE_DISP24,
		MODE_POSTINC,
		MODE_ABS8,
		MODE_ABS16,
		MODE_ABS24,
		MODE_STORE_IND
	} mode_t;
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_RUN
	} phase_t;
endpackage

// *** common/reg_file_if.sv ***
// carrier between the execute sequencer and the register file
`timescale 1ns/100ps
interface reg_file_if;
	logic [3:0] byte_rd_idx;
	logic [7:0] byte_rd_data;
	logic [2:0] long_rd_idx;
	logic [31:0] long_rd_data;
	logic [2:0] dbg_rd_idx;
	logic [31:0] dbg_rd_data;
	logic byte_wr_en;
	logic [3:0] byte_wr_idx;
	logic [7:0] byte_wr_data;
	logic long_wr_en;
	logic [2:0] long_wr_idx;
	logic [31:0] long_wr_data;
	modport seq (output byte_rd_idx, long_rd_idx, dbg_rd_idx, byte_wr_en, byte_wr_idx, byte_wr_data,
		long_wr_en, long_wr_idx, long_wr_data, input byte_rd_data, long_rd_data, dbg_rd_data);
	modport store (input byte_rd_idx, long_rd_idx, dbg_rd_idx, byte_wr_en, byte_wr_idx, byte_wr_data,
		long_wr_en, long_wr_idx, long_wr_data, output byte_rd_data, long_rd_data, dbg_rd_data);
endinterface

// *** core/general_reg_file.sv ***
// eight 32-bit general registers with byte and long views
`timescale 1ns/100ps
module general_reg_file (
	input wire logic clock_in,
	input wire logic srst_in,
	reg_file_if.store rf
);
	typedef struct packed {
		logic [7:0][31:0] longs;
	} rf_state_t;
	rf_state_t st_r;
	rf_state_t st_nxt;

	// byte index: 0..7 high bytes, 8..15 low bytes of the low words
	function automatic logic [7:0] byte_of(input logic [7:0][31:0] l, input logic [3:0] idx);
		logic [31:0] w;
		w = l[idx[2:0]];
		return idx[3] ? w[7:0] : w[15:8];
	endfunction

	assign rf.byte_rd_data = byte_of(st_r.longs, rf.byte_rd_idx);
	assign rf.long_rd_data = st_r.longs[rf.long_rd_idx];
	assign rf.dbg_rd_data = st_r.longs[rf.dbg_rd_idx];

	always_comb begin
		st_nxt = st_r;
		if (rf.long_wr_en) begin
			st_nxt.longs[rf.long_wr_idx] = rf.long_wr_data;
		end
		// byte write lands after the long write, so a destination that aliases the address register wins
		if (rf.byte_wr_en) begin
			if (rf.byte_wr_idx[3]) begin
				st_nxt.longs[rf.byte_wr_idx[2:0]][7:0] = rf.byte_wr_data;
			end else begin
				st_nxt.longs[rf.byte_wr_idx[2:0]][15:8] = rf.byte_wr_data;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			st_r <= {8{byte_move_pkg::LONG_RESET}};
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule

// *** testbench/byte_move_props.sv ***
// port assertions for the byte move execute unit
`timescale 1ns/100ps
module byte_move_props (
	input wire logic clock_in,
	input wire logic srst_in,
	input wire logic instr_valid_in,
	input wire byte_move_pkg::mode_t instr_mode_in,
	input wire logic instr_ready_out,
	input wire logic done_out,
	input wire logic [3:0] instr_len_out,
	input wire logic [3:0] instr_states_out,
	input wire logic [7:0] flags_out,
	input wire logic mem_req_out,
	input wire logic mem_we_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (srst_in);
	sequence s_acc(byte_move_pkg::mode_t m);
		instr_valid_in && instr_ready_out && instr_mode_in == m;
	endsequence
	sequence s_len(logic [3:0] l, logic [3:0] s);
		instr_len_out == l && instr_states_out == s;
	endsequence
	property p_imm; s_acc(byte_move_pkg::MODE_IMM) |=> !done_out ##1 !done_out ##1 done_out; endproperty
	a_imm: assert property (p_imm) else $error("imm timing");
	property p_nomem; s_acc(byte_move_pkg::MODE_REG) |=> !mem_req_out [*2]; endproperty
	a_nomem: assert property (p_nomem) else $error("reg move used bus");
	property p_req; s_acc(byte_move_pkg::MODE_IND) |-> ##[1:2] mem_req_out; endproperty
	a_req: assert property (p_req) else $error("no operand access");
	property p_we; s_acc(byte_move_pkg::MODE_STORE_IND) |-> ##2 mem_req_out && mem_we_out; endproperty
	a_we: assert property (p_we) else $error("store not issued as a write");
	property p_ld; s_acc(byte_move_pkg::MODE_POSTINC) |-> ##2 mem_req_out && !mem_we_out; endproperty
	a_ld: assert property (p_ld) else $error("load issued as a write");
	property p_busy; instr_valid_in && instr_ready_out |=> !instr_ready_out; endproperty
	a_busy: assert property (p_busy) else $error("ready while busy");
	property p_pi; s_acc(byte_move_pkg::MODE_POSTINC) |=> s_len(4'h2, 4'h6); endproperty
	a_pi: assert property (p_pi) else $error("postinc size");
	property p_d16; s_acc(byte_move_pkg::MODE_DISP16) |=> s_len(4'h4, 4'h6); endproperty
	a_d16: assert property (p_d16) else $error("disp16 size");
	property p_d24; s_acc(byte_move_pkg::MODE_DISP24) |=> s_len(4'h8, 4'hA); endproperty
	a_d24: assert property (p_d24) else $error("disp24 size");
	property p_v; done_out |-> !flags_out[1]; endproperty
	a_v: assert property (p_v) else $error("overflow flag set");
	// the move's completion may touch only n, z and v
	property p_keep; done_out |-> flags_out[7:4] == $past(flags_out[7:4]) && flags_out[0] == $past(flags_out[0]);
	endproperty
	a_keep: assert property (p_keep) else $error("kept flags changed");
endmodule

// *** testbench/mem_model.sv ***
// memory behind the bus controller, answering after delay_in spare cycles
`timescale 1ns/100ps
module mem_model (
	input wire logic clock_in,
	input wire logic req_in,
	input wire logic [23:0] addr_in,
	input wire logic [3:0] delay_in,
	output logic ack_out,
	output logic [7:0] rdata_out
);
	logic [4:0] cnt = 5'h1F;
	logic [23:0] a = 24'h0;
	// data outside the ack cycle is inverted so a late sample cannot pass
	assign ack_out = cnt == 5'h0;
	assign rdata_out = ack_out ? a[7:0] ^ 8'hC3 : ~(a[7:0] ^ 8'hC3);
	always @(posedge clock_in) begin
		if (req_in) begin
			cnt <= {1'h0, delay_in};
			a <= addr_in;
		end else if (cnt != 5'h1F) begin
			cnt <= cnt - 5'h1;
		end
	end
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the byte move execute unit
`timescale 1ns/100ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin err_count++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module testbench;
	logic clock_in = 1'h0, srst_in = 1'h1, instr_valid_in = 1'h0, reg_wr_in = 1'h0, reg_rd_in = 1'h0;
	logic instr_ready_out, done_out, mem_req_out, mem_we_out, mem_ack_in;
	byte_move_pkg::mode_t instr_mode_in = byte_move_pkg::MODE_IMM;
	logic [3:0] instr_dst_in = 4'h0, instr_src_in = 4'h0, reg_addr_in = 4'h0, dly = 4'h0;
	logic [3:0] instr_len_out, instr_states_out;
	logic [23:0] instr_ext_in = 24'h0, mem_addr_out;
	logic [7:0] flags_out, mem_wdata_out, mem_rdata_in, fl = 8'h80;
	logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
	int err_count = 0, total_checks = 0;
	byte_move_execute_unit u_dut (.clock_in, .srst_in, .instr_valid_in, .instr_mode_in, .instr_dst_in,
		.instr_src_in, .instr_ext_in, .instr_ready_out, .done_out, .instr_len_out, .instr_states_out, .flags_out,
		.mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out, .mem_ack_in, .mem_rdata_in, .reg_addr_in,
		.reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out);
	mem_model u_mem (.clock_in, .req_in(mem_req_out), .addr_in(mem_addr_out), .delay_in(dly),
		.ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
	initial begin
		forever #2 clock_in = ~clock_in;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic wr(logic [3:0] a, logic [31:0] d);
		@(posedge clock_in);
		reg_wr_in <= 1'h1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clock_in);
		reg_wr_in <= 1'h0;
	endtask
	task automatic rdc(logic [3:0] a, logic [31:0] e);
		@(posedge clock_in);
		reg_rd_in <= 1'h1;
		reg_addr_in <= a;
		@(posedge clock_in);
		reg_rd_in <= 1'h0;
		#1;
		`CHK("reg", e, reg_rdata_out)
	endtask
	// b is the byte moved; expected flags follow from it and the old flags
	task automatic run(byte_move_pkg::mode_t m, logic [3:0] d, s, logic [23:0] e, logic [3:0] l, st, logic [7:0] b);
		int n;
		n = 0;
		@(posedge clock_in);
		instr_valid_in <= 1'h1;
		instr_mode_in <= m;
		instr_dst_in <= d;
		instr_src_in <= s;
		instr_ext_in <= e;
		@(posedge clock_in);
		instr_valid_in <= 1'h0;
		do begin
			@(posedge clock_in);
			#1;
			n++;
		end while (done_out !== 1'h1 && n < 40);
		if (n == 40) begin
			err_count++;
			stop_test();
		end else begin
			fl = (fl & 8'hF1) | {4'h0, b[7], b == 8'h00, 2'h0};
			`CHK("len", l, instr_len_out)
			`CHK("states", st, instr_states_out)
			`CHK("cycles", 1'h1, dly == 4'h0 ? n == int'(st) : n > int'(st))
			`CHK("flags", fl, flags_out)
			`CHK("ready", 1'h1, instr_ready_out)
		end
	endtask
	task automatic t_regs();
		rdc(4'h8, 32'h80);
		rdc(4'h9, 32'h0);
		wr(4'h5, 32'h12345678);
		rdc(4'h5, 32'h12345678);
		wr(4'h1, 32'h1000);
		wr(4'h8, 32'hE3);
		fl = 8'hE3;
		$display("t_regs done");
	endtask
	task automatic t_moves();
		run(byte_move_pkg::MODE_IMM, 4'h5, 4'h0, 24'hAB, 4'h2, 4'h2, 8'hAB);
		run(byte_move_pkg::MODE_IMM, 4'hD, 4'h0, 24'h0, 4'h2, 4'h2, 8'h00);
		run(byte_move_pkg::MODE_REG, 4'hA, 4'h5, 24'h0, 4'h2, 4'h2, 8'hAB);
		rdc(4'h5, 32'h1234AB00);
		rdc(4'h2, 32'hAB);
		rdc(4'h8, {24'h000000, fl});
		$display("t_moves done");
	endtask
	task automatic t_abs();
		run(byte_move_pkg::MODE_ABS8, 4'h8, 4'h0, 24'h000012, 4'h2, 4'h4, 8'hD1);
		run(byte_move_pkg::MODE_ABS16, 4'h0, 4'h0, 24'h001234, 4'h4, 4'h6, 8'hF7);
		run(byte_move_pkg::MODE_ABS24, 4'h4, 4'h0, 24'h123456, 4'h6, 4'h8, 8'h95);
		rdc(4'h0, 32'hF7D1);
		rdc(4'h4, 32'h9500);
		$display("t_abs done");
	endtask
	task automatic t_loads();
		run(byte_move_pkg::MODE_IND, 4'hB, 4'h1, 24'h0, 4'h2, 4'h4, 8'hC3);
		run(byte_move_pkg::MODE_DISP16, 4'hE, 4'h1, 24'hFFFE, 4'h4, 4'h6, 8'h3D);
		`CHK("addr", 24'h000FFE, mem_addr_out)
		run(byte_move_pkg::MODE_DISP24, 4'h6, 4'h1, 24'h123, 4'h8, 4'hA, 8'hE0);
		`CHK("addr", 24'h001123, mem_addr_out)
		rdc(4'h6, 32'hE03D);
		rdc(4'h3, 32'hC3);
		$display("t_loads done");
	endtask
	task automatic t_post();
		run(byte_move_pkg::MODE_POSTINC, 4'hF, 4'h1, 24'h0, 4'h2, 4'h6, 8'hC3);
		rdc(4'h1, 32'h1001);
		run(byte_move_pkg::MODE_STORE_IND, 4'h1, 4'h5, 24'h0, 4'h2, 4'h4, 8'hAB);
		`CHK("waddr", 24'h001001, mem_addr_out)
		`CHK("wdata", 8'hAB, mem_wdata_out)
		// a slow memory must stretch the load, not corrupt it
		dly = 4'h8;
		run(byte_move_pkg::MODE_DISP16, 4'hF, 4'h1, 24'h10, 4'h4, 4'h6, 8'hD2);
		rdc(4'h7, 32'hD2);
		$display("t_post done");
	endtask
	initial begin
		repeat (6) @(posedge clock_in);
		srst_in <= 1'h0;
		t_regs();
		t_moves();
		t_loads();
		t_abs();
		t_post();
		stop_test();
	end
endmodule
bind byte_move_execute_unit byte_move_props u_props (.clock_in, .srst_in, .instr_valid_in, .instr_mode_in,
	.instr_ready_out, .done_out, .instr_len_out, .instr_states_out, .flags_out, .mem_req_out, .mem_we_out);
